// ==== verilog/serial_defines.vh ====
`ifndef SERIAL_DEFINES_VH
`define SERIAL_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define OFF_TX_CTRL     8'h00
`define OFF_RX_CTRL     8'h04
`define OFF_BAUD_CTRL   8'h08
`define OFF_DIVISOR     8'h0c
`define OFF_TX_BUF      8'h10
`define OFF_RX_BUF      8'h14
`define OFF_FLAGS       8'h18
`define OFF_ENABLES     8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_CLK_SRC     7
`define BIT_NINE_TX     6
`define BIT_TX_EN       5
`define BIT_SYNC        4
`define BIT_SEND_BRK    3
`define BIT_SR_EMPTY    1
`define BIT_NINTH_TX    0
`define BIT_PORT_EN     7
`define BIT_RX_EN       4
`define BIT_RX_IDLE     6
`define BIT_CLK_POL     4
`define BIT_DIV16       3
`define BIT_WAKE_EN     1
`define BIT_RX_FLAG     5
`define BIT_TXE_FLAG    4

// ----------------------------------------------------------------------------
// Reset values and frame constants
// ----------------------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_DIVISOR     16'h0000
`define BRK_ZERO_BITS   4'hc
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== verilog/usart_break_wake_sync_master_tx.v ====
// How it works
// - Wake enable idles receiver, watches line only
// - Wake sets receive flag; rising edge clears wake
// - Reading receive buffer clears receive flag
// - Break is start, twelve zeros, stop
// - Send-break plus enable sends zeros, ignores data
// - Send-break clears after break stop bit
// - Shift-empty status tracks breaks like characters
// - Break wake: two edges, flag, then byte
// - Sync master turns pins into clock, data
// - Sync mode is half duplex
// - Master drives clock; polarity sets idle level
// - Shift reloads after last bit, sets empty flag
// - Buffer-empty flag clears only on buffer write
// - Shift-empty bit read-only, set when empty
// - Falling receive edge is wake event
`include "serial_defines.vh"

module usart_break_wake_sync_master_tx (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_reset,
   // AXI4-Lite write address and data
   input  wire [7:0]  i_s_axi_awaddr,
   input  wire        i_s_axi_awvalid,
   output wire        o_s_axi_awready,
   input  wire [31:0] i_s_axi_wdata,
   input  wire [3:0]  i_s_axi_wstrb,
   input  wire        i_s_axi_wvalid,
   output wire        o_s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  o_s_axi_bresp,
   output wire        o_s_axi_bvalid,
   input  wire        i_s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  i_s_axi_araddr,
   input  wire        i_s_axi_arvalid,
   output wire        o_s_axi_arready,
   output wire [31:0] o_s_axi_rdata,
   output wire [1:0]  o_s_axi_rresp,
   output wire        o_s_axi_rvalid,
   input  wire        i_s_axi_rready,
   // Serial pins
   output wire        o_tx_ck,
   input  wire        i_receive_or_data_line,
   output wire        o_dt,
   output wire        o_dt_oe
);

   // --------------------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------------------
   // Effective baud divisor: 16-bit or low byte only
   function [15:0] divisor_of;
      input       wide;
      input [15:0] div;
      begin
         divisor_of = wide ? div : {8'h00, div[7:0]};
      end
   endfunction

   // Mapped address check
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a[1:0] == 2'b00) && (a <= `OFF_ENABLES);
      end
   endfunction

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   localparam [1:0] TX_IDLE  = 2'd0;
   localparam [1:0] TX_ASYNC = 2'd1;
   localparam [1:0] TX_SYNC  = 2'd2;
   localparam [1:0] RX_IDLE  = 2'd0;
   localparam [1:0] RX_START = 2'd1;
   localparam [1:0] RX_DATA  = 2'd2;
   localparam [1:0] RX_STOP  = 2'd3;

   reg [7:0]  tx_ctrl_q;                 // Transmit control/status
   reg [7:0]  rx_ctrl_q;                 // Receive control
   reg [7:0]  baud_ctrl_q;               // Baud control
   reg [15:0] divisor_q;                 // Baud divisor high:low
   reg [7:0]  tx_buf_q;                  // Transmit holding buffer
   reg        tx_full_q;                 // Holding buffer occupied
   reg [7:0]  rx_buf_q;                  // Receive buffer
   reg        rx_flag_q;                 // Receive complete flag
   reg [7:0]  enables_q;                 // Interrupt enable bits, stored only
   reg        wake_seen_q;               // Wake falling edge already seen
   reg [1:0]  tx_state_q;                // Transmit state
   reg [15:0] tx_shift_q;                // Transmit shift register
   reg [3:0]  tx_bits_q;                 // Bits left in frame
   reg [15:0] tx_cnt_q;                  // Transmit baud counter
   reg        tx_phase_q;                // Sync clock phase
   reg        tx_brk_q;                  // Frame in flight is a break
   reg [1:0]  rx_state_q;                // Receive state
   reg [15:0] rx_cnt_q;                  // Receive baud counter
   reg [2:0]  rx_bits_q;                 // Receive bit index
   reg [7:0]  rx_shift_q;                // Receive shift register
   reg        rx_m1_q;                   // Synchroniser stage 1
   reg        rx_m2_q;                   // Synchroniser stage 2
   reg        rx_d_q;                    // Delayed line for edges
   reg        tx_ck_q;                   // Pin register: TX/CK
   reg        dt_q;                      // Pin register: data out
   reg        dt_oe_q;                   // Pin register: data enable
   reg        awready_q;                 // AXI write address ready
   reg        wready_q;                  // AXI write data ready
   reg        bvalid_q;                  // AXI write response valid
   reg [1:0]  bresp_q;                   // AXI write response code
   reg        arready_q;                 // AXI read address ready
   reg        rvalid_q;                  // AXI read valid
   reg [1:0]  rresp_q;                   // AXI read response code
   reg [31:0] rdata_q;                   // AXI read data

   // --------------------------------------------------------------------------
   // Decoded controls
   // --------------------------------------------------------------------------
   wire [15:0] div_w    = divisor_of(baud_ctrl_q[`BIT_DIV16], divisor_q);
   wire        port_en  = rx_ctrl_q[`BIT_PORT_EN];
   wire        sync_md  = tx_ctrl_q[`BIT_SYNC];
   wire        master   = sync_md & tx_ctrl_q[`BIT_CLK_SRC];
   wire        tx_en    = tx_ctrl_q[`BIT_TX_EN] & port_en;
   wire        nine     = tx_ctrl_q[`BIT_NINE_TX];
   wire        wake_en  = baud_ctrl_q[`BIT_WAKE_EN];
   wire        fall_w   = rx_d_q & ~rx_m2_q;
   wire        rise_w   = ~rx_d_q & rx_m2_q;
   wire        tx_tick  = (tx_cnt_q == 16'h0000);
   wire        rx_tick  = (rx_cnt_q == 16'h0000);
   wire        tx_idle  = (tx_state_q == TX_IDLE);
   // Sync slave is not served here; only master or async may start
   wire        can_load = tx_idle & tx_full_q & tx_en & (~sync_md | master);
   wire        wr_go    = i_s_axi_awvalid & i_s_axi_wvalid & ~bvalid_q & ~awready_q;
   wire        wr_ok    = wr_go & is_mapped(i_s_axi_awaddr);
   wire        wr_b0    = wr_ok & i_s_axi_wstrb[0];
   wire        rd_go    = i_s_axi_arvalid & ~rvalid_q & ~arready_q;
   wire        rd_rxbuf = rd_go & (i_s_axi_araddr == `OFF_RX_BUF);
   wire        tx_done  = (tx_state_q == TX_ASYNC) & tx_tick & (tx_bits_q == 4'h1);

   // --------------------------------------------------------------------------
   // Receive line synchroniser
   // --------------------------------------------------------------------------
   // Two stages before any logic; the third is the edge reference
   always @(posedge i_clk) begin
      if (i_reset) begin
         rx_m1_q <= 1'b1;
         rx_m2_q <= 1'b1;
         rx_d_q  <= 1'b1;
      end else begin
         rx_m1_q <= i_receive_or_data_line;
         rx_m2_q <= rx_m1_q;
         rx_d_q  <= rx_m2_q;
      end
   end

   // --------------------------------------------------------------------------
   // AXI4-Lite slave
   // --------------------------------------------------------------------------
   // Address and data are taken together; one beat at a time
   always @(posedge i_clk) begin
      if (i_reset) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= `RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
      end else begin
         awready_q <= wr_go;
         wready_q  <= wr_go;
         if (wr_go) begin                // Response follows both beats
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(i_s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (i_s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         arready_q <= rd_go;
         if (rd_go) begin                // Read data latched with address
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(i_s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (i_s_axi_araddr)
               `OFF_TX_CTRL:   rdata_q <= {24'h000000, tx_ctrl_q[7:2], tx_idle, tx_ctrl_q[0]};
               `OFF_RX_CTRL:   rdata_q <= {24'h000000, rx_ctrl_q};
               `OFF_BAUD_CTRL: rdata_q <= {24'h000000, baud_ctrl_q[7], rx_state_q == RX_IDLE,
                                           baud_ctrl_q[5:0]};
               `OFF_DIVISOR:   rdata_q <= {16'h0000, divisor_q};
               `OFF_TX_BUF:    rdata_q <= {24'h000000, tx_buf_q};
               `OFF_RX_BUF:    rdata_q <= {24'h000000, rx_buf_q};
               `OFF_FLAGS:     rdata_q <= {26'h0000000, rx_flag_q, ~tx_full_q, 4'h0};
               `OFF_ENABLES:   rdata_q <= {24'h000000, enables_q};
               default:        rdata_q <= 32'h0000_0000;
            endcase
         end else if (i_s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Control registers
   // --------------------------------------------------------------------------
   // Software writes take priority over hardware clears of its own bits
   always @(posedge i_clk) begin
      if (i_reset) begin
         tx_ctrl_q   <= `RST_BYTE;
         rx_ctrl_q   <= `RST_BYTE;
         baud_ctrl_q <= `RST_BYTE;
         divisor_q   <= `RST_DIVISOR;
         enables_q   <= `RST_BYTE;
         wake_seen_q <= 1'b0;
      end else begin
         // Break ends: send-break drops after its stop bit
         if (tx_done && tx_brk_q) begin
            tx_ctrl_q[`BIT_SEND_BRK] <= 1'b0;
         end
         // Wake: falling edge arms, following rising edge disarms
         if (!wake_en || sync_md) begin
            wake_seen_q <= 1'b0;
         end else if (!wake_seen_q && fall_w) begin
            wake_seen_q <= 1'b1;
         end else if (wake_seen_q && rise_w) begin
            wake_seen_q <= 1'b0;
            baud_ctrl_q[`BIT_WAKE_EN] <= 1'b0;
         end
         if (wr_b0) begin
            case (i_s_axi_awaddr)
               `OFF_TX_CTRL:   tx_ctrl_q   <= i_s_axi_wdata[7:0] & 8'hfd;
               `OFF_RX_CTRL:   rx_ctrl_q   <= i_s_axi_wdata[7:0];
               `OFF_BAUD_CTRL: baud_ctrl_q <= i_s_axi_wdata[7:0] & 8'hbf;
               `OFF_DIVISOR:   divisor_q[7:0] <= i_s_axi_wdata[7:0];
               `OFF_ENABLES:   enables_q   <= i_s_axi_wdata[7:0];
               default:        divisor_q   <= divisor_q;
            endcase
         end
         if (wr_ok && i_s_axi_wstrb[1] && i_s_axi_awaddr == `OFF_DIVISOR) begin
            divisor_q[15:8] <= i_s_axi_wdata[15:8];
         end
      end
   end

   // --------------------------------------------------------------------------
   // Transmit holding buffer
   // --------------------------------------------------------------------------
   // Empty flag is the inverse of occupancy: only a buffer write clears it
   always @(posedge i_clk) begin
      if (i_reset) begin
         tx_buf_q  <= `RST_BYTE;
         tx_full_q <= 1'b0;
      end else begin
         if (wr_b0 && i_s_axi_awaddr == `OFF_TX_BUF) begin
            tx_buf_q  <= i_s_axi_wdata[7:0];
            tx_full_q <= 1'b1;
         end else if (can_load) begin
            tx_full_q <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Transmit shifter
   // --------------------------------------------------------------------------
   // Loads in one cycle once the previous frame's last bit is out
   always @(posedge i_clk) begin
      if (i_reset) begin
         tx_state_q <= TX_IDLE;
         tx_shift_q <= 16'hffff;
         tx_bits_q  <= 4'h0;
         tx_cnt_q   <= 16'h0000;
         tx_phase_q <= 1'b0;
         tx_brk_q   <= 1'b0;
      end else begin
         case (tx_state_q)
            TX_IDLE: begin
               tx_phase_q <= 1'b0;
               tx_cnt_q   <= div_w;
               if (can_load && master) begin
                  tx_state_q <= TX_SYNC;
                  tx_shift_q <= {7'h00, tx_ctrl_q[`BIT_NINTH_TX], tx_buf_q};
                  tx_bits_q  <= nine ? 4'h9 : 4'h8;
                  tx_brk_q   <= 1'b0;
               end else if (can_load && tx_ctrl_q[`BIT_SEND_BRK]) begin
                  // Break: buffer data ignored, start + twelve zeros + stop
                  tx_state_q <= TX_ASYNC;
                  tx_shift_q <= 16'he000;
                  tx_bits_q  <= `BRK_ZERO_BITS + 4'h2;
                  tx_brk_q   <= 1'b1;
               end else if (can_load) begin
                  tx_state_q <= TX_ASYNC;
                  tx_shift_q <= nine ? {6'h3f, tx_ctrl_q[`BIT_NINTH_TX], tx_buf_q, 1'b0}
                                     : {6'h3f, 1'b1, tx_buf_q, 1'b0};
                  tx_bits_q  <= nine ? 4'hb : 4'ha;
                  tx_brk_q   <= 1'b0;
               end
            end
            TX_ASYNC: begin
               // One bit per divisor period, low bit first
               if (tx_tick) begin
                  tx_cnt_q   <= div_w;
                  tx_shift_q <= {1'b1, tx_shift_q[15:1]};
                  tx_bits_q  <= tx_bits_q - 4'h1;
                  if (tx_bits_q == 4'h1) begin
                     tx_state_q <= TX_IDLE;
                  end
               end else begin
                  tx_cnt_q <= tx_cnt_q - 16'h0001;
               end
            end
            TX_SYNC: begin
               // Two divisor periods per clock: idle half, active half
               if (tx_tick) begin
                  tx_cnt_q   <= div_w;
                  tx_phase_q <= ~tx_phase_q;
                  if (tx_phase_q) begin
                     tx_shift_q <= {1'b0, tx_shift_q[15:1]};
                     tx_bits_q  <= tx_bits_q - 4'h1;
                     if (tx_bits_q == 4'h1) begin
                        tx_state_q <= TX_IDLE;
                     end
                  end
               end else begin
                  tx_cnt_q <= tx_cnt_q - 16'h0001;
               end
            end
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Receiver and receive flag
   // --------------------------------------------------------------------------
   // Async only; held idle in sync mode and while wake is enabled
   always @(posedge i_clk) begin
      if (i_reset) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q   <= 16'h0000;
         rx_bits_q  <= 3'h0;
         rx_shift_q <= `RST_BYTE;
         rx_buf_q   <= `RST_BYTE;
         rx_flag_q  <= 1'b0;
      end else begin
         // Read clears the flag unless a new event lands the same cycle
         if (rd_rxbuf) begin
            rx_flag_q <= 1'b0;
         end
         if (wake_en && !sync_md && !wake_seen_q && fall_w) begin
            rx_flag_q <= 1'b1;
         end
         case (rx_state_q)
            RX_IDLE: begin
               rx_cnt_q <= {1'b0, div_w[15:1]};
               // Half duplex and wake monitoring suspend reception
               if (fall_w && !wake_en && !sync_md && port_en && rx_ctrl_q[`BIT_RX_EN]) begin
                  rx_state_q <= RX_START;
               end
            end
            RX_START: begin
               if (rx_tick) begin
                  rx_cnt_q   <= div_w;
                  rx_bits_q  <= 3'h0;
                  rx_state_q <= rx_m2_q ? RX_IDLE : RX_DATA;
               end else begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_cnt_q   <= div_w;
                  rx_shift_q <= {rx_m2_q, rx_shift_q[7:1]};
                  rx_bits_q  <= rx_bits_q + 3'h1;
                  if (rx_bits_q == 3'h7) begin
                     rx_state_q <= RX_STOP;
                  end
               end else begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_state_q <= RX_IDLE;
                  rx_buf_q   <= rx_shift_q;
                  rx_flag_q  <= 1'b1;
               end else begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end
            end
            default: rx_state_q <= RX_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Pin registers
   // --------------------------------------------------------------------------
   // Port off: pins released; sync master: clock plus driven data
   always @(posedge i_clk) begin
      if (i_reset) begin
         tx_ck_q <= 1'b1;
         dt_q    <= 1'b0;
         dt_oe_q <= 1'b0;
      end else if (!port_en) begin
         tx_ck_q <= 1'b1;
         dt_q    <= 1'b0;
         dt_oe_q <= 1'b0;
      end else if (master) begin
         // Clock idles at the polarity level, inverts in active half
         tx_ck_q <= baud_ctrl_q[`BIT_CLK_POL] ^ ((tx_state_q == TX_SYNC) & tx_phase_q);
         dt_q    <= tx_shift_q[0];
         dt_oe_q <= (tx_state_q == TX_SYNC);
      end else begin
         tx_ck_q <= (tx_state_q == TX_ASYNC) ? tx_shift_q[0] : 1'b1;
         dt_q    <= 1'b0;
         dt_oe_q <= 1'b0;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   assign o_s_axi_awready = awready_q;
   assign o_s_axi_wready  = wready_q;
   assign o_s_axi_bresp   = bresp_q;
   assign o_s_axi_bvalid  = bvalid_q;
   assign o_s_axi_arready = arready_q;
   assign o_s_axi_rdata   = rdata_q;
   assign o_s_axi_rresp   = rresp_q;
   assign o_s_axi_rvalid  = rvalid_q;
   assign o_tx_ck         = tx_ck_q;
   assign o_dt            = dt_q;
   assign o_dt_oe         = dt_oe_q;

endmodule // usart_break_wake_sync_master_tx

// ==== test/usart_break_wake_sync_master_tx_asserts.sv ====
// Bus handshake checker on the block's ports
module usart_break_wake_sync_master_tx_asserts (
   input wire        i_clk, i_reset, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready,
   input wire        i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready,
   input wire        o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_dt_oe,
   input wire [7:0]  i_s_axi_awaddr, i_s_axi_araddr,
   input wire [1:0]  o_s_axi_bresp, o_s_axi_rresp,
   input wire [31:0] o_s_axi_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Request taken at this edge
   wire wtake = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid && !o_s_axi_awready;
   wire rtake = i_s_axi_arvalid && !o_s_axi_rvalid && !o_s_axi_arready;
   a_write_answer: assert property (wtake |=> o_s_axi_awready && o_s_axi_wready && o_s_axi_bvalid)
      else $error("write not answered");
   a_ready_pulse: assert property (o_s_axi_awready |=> !o_s_axi_awready && !o_s_axi_wready)
      else $error("ready longer than one cycle");
   a_bvalid_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write response dropped");
   a_write_slverr: assert property (wtake && i_s_axi_awaddr > 8'h1c |=> o_s_axi_bresp == 2'h2)
      else $error("unmapped write not refused");
   a_read_answer: assert property (rtake |=> o_s_axi_arready && o_s_axi_rvalid)
      else $error("read not answered");
   a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read data moved");
   a_read_unmapped: assert property (rtake && i_s_axi_araddr > 8'h1c |=> o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 0)
      else $error("unmapped read not refused");
   a_rdata_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   c_write: cover property (wtake);
   c_unmapped: cover property (rtake && i_s_axi_araddr > 8'h1c);
   c_drive: cover property ($rose(o_dt_oe));
endmodule // usart_break_wake_sync_master_tx_asserts

bind usart_break_wake_sync_master_tx usart_break_wake_sync_master_tx_asserts u_chk (.*);

// ==== test/serial_peer.sv ====
// Far-side serial node: drives the receive line, watches clock and data
module serial_peer (
   input  wire  i_clk,
   input  wire  i_line,
   input  wire  i_dt,
   output logic o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_line = 1'b1; // Mark level between frames
   // Drive n bits LSB first at 160 ns each, then idle high
   task automatic send(input logic [12:0] v, input int n);
      #3;
      for (int i = 0; i < n; i++) begin
         o_line = v[i];
         #160;
      end
      o_line = 1'b1;
   endtask
   // Sample an async frame at bit centres
   task automatic grab(output logic [7:0] b, input int bt);
      @(negedge i_line);
      repeat (bt + bt / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = i_line;
         repeat (bt) @(posedge i_clk);
      end
   endtask
   // Clocks spent low in the next low run
   task automatic low_len(output int n);
      @(negedge i_line);
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (!i_line);
   endtask
   // Take data as the shift clock enters its active level
   task automatic sgrab(output logic [8:0] b, input logic pol, input int nb);
      b = 0;
      for (int i = 0; i < nb; i++) begin
         wait (i_line == !pol);
         b[i] = i_dt;
         wait (i_line == pol);
      end
   endtask
endmodule // serial_peer

// ==== test/usart_break_wake_sync_master_tx_tb_top.sv ====
module usart_break_wake_sync_master_tx_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic        tx_ck, dt, dt_oe, peer_line;
   logic [7:0]  awaddr, araddr, b, got;
   logic [8:0]  g9; // Sync word seen, ninth bit on top
   logic [31:0] wdata, rdata, d, seed;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp_q;
   int          error_cnt, checks_done, n;
   wire         receive_or_data_line = dt_oe ? dt : peer_line; // Shared data wire
   usart_break_wake_sync_master_tx dut (.i_clk(clk), .i_reset(rst), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .o_tx_ck(tx_ck), .i_receive_or_data_line(receive_or_data_line), .o_dt(dt), .o_dt_oe(dt_oe));
   serial_peer p (.i_clk(clk), .i_line(tx_ck), .i_dt(receive_or_data_line), .o_line(peer_line));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   function automatic int brk_clks(int dv); // Low clocks of a break
      return 13 * (dv + 1);
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit ad, wd; // Channel taken
      @(posedge clk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk);
         if (awready) begin awvalid <= 0; ad = 1; end
         if (wready) begin wvalid <= 0; wd = 1; end
      end while (!(ad && wd));
      while (!bvalid) @(posedge clk);
      resp_q = bresp; bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge clk);
      v = rdata; resp_q = rresp; rready <= 0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      rd(a, d);
      chk(nm, d, exp);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin // Watchdog
      #300us;
      error_cnt++;
      wrap_up();
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; rst = 1;
      seed = $urandom(32'h5b2d);
      repeat (2) @(posedge clk);
      rst <= 0;
      rdc(8'h18, 32'h10, "flags reset");
      wr(8'h18, 0); rdc(8'h18, 32'h10, "flags ro");
      wr(8'h00, 0); rdc(8'h00, 32'h02, "shift empty");
      rdc(8'h24, 0, "unmapped"); chk("rresp", resp_q, 2);
      wr(8'h0c, 15); wr(8'h04, 32'h80); wr(8'h00, 32'h20);
      repeat (3) begin
         b = $urandom;
         fork p.grab(got, 16); wr(8'h10, b); join
         chk("tx byte", got, b);
      end
      wr(8'h00, 32'h28); b = $urandom;
      fork p.low_len(n); begin wr(8'h10, b); wr(8'h10, 8'h55); rdc(8'h00, 32'h28, "break busy"); end join
      chk("break low", n, brk_clks(15));
      p.grab(got, 16); chk("sync byte", got, 8'h55);
      rd(8'h00, d); chk("send break", d[3], 0);
      wr(8'h04, 32'h90); rdc(8'h08, 32'h40, "rx idle"); wr(8'h08, 32'h02);
      fork p.send(0, 13); begin repeat (20) @(posedge clk); rdc(8'h18, 32'h30, "wake flag"); end join
      repeat (8) @(posedge clk);
      rd(8'h08, d); chk("wake clear", d[1], 0);
      rd(8'h14, d); rdc(8'h18, 32'h10, "flag clear");
      b = $urandom; p.send({1'b1, b, 1'b0}, 10);
      rdc(8'h18, 32'h30, "rx flag"); rdc(8'h14, {24'h0, b}, "rx byte");
      wr(8'h0c, 7); // Shift clock period 160 ns
      for (int pol = 0; pol < 2; pol++) begin
         wr(8'h08, pol << 4); wr(8'h00, pol ? 32'hf1 : 32'hb0); repeat (2) @(posedge clk);
         chk("ck idle", tx_ck, pol);
         b = $urandom;
         fork p.sgrab(g9, pol, 8 + pol); wr(8'h10, b); join
         chk("sync data", g9, {pol[0], b});
      end
      wr(8'h24, 0); chk("bresp", resp_q, 2);
      wrap_up();
   end
endmodule // usart_break_wake_sync_master_tx_tb_top
